/* logic/ufic_defines.svh */
// Register indices, field positions, reset values and timing counts
`ifndef UFIC_DEFINES_SVH
`define UFIC_DEFINES_SVH

// Register indices; byte address is four times the index
`define UFIC_IDX_RBUF 6'h00
`define UFIC_IDX_IEN 6'h01
`define UFIC_IDX_IID 6'h02
`define UFIC_IDX_LSTAT 6'h05

// fifo_control fields
`define UFIC_FCTL_EN 0
`define UFIC_FCTL_RXRST 1
`define UFIC_FCTL_TXRST 2
`define UFIC_FCTL_TRIG_LO 6
`define UFIC_FCTL_TRIG_HI 7

// interrupt_enable fields
`define UFIC_IEN_RDA 0
`define UFIC_IEN_TXE 1
`define UFIC_IEN_LS 2

// Reset values
`define UFIC_IEN_RST 3'h0
`define UFIC_FIFO_EN_RST 1'h0
`define UFIC_TRIG_RST 2'h0

// Receive trigger levels in bytes
`define UFIC_TRIG_L0 5'h01
`define UFIC_TRIG_L1 5'h04
`define UFIC_TRIG_L2 5'h08
`define UFIC_TRIG_L3 5'h0E

// interrupt_identification codes, bits 3..0
`define UFIC_IID_NONE 4'h1
`define UFIC_IID_LS 4'h6
`define UFIC_IID_RDA 4'h4
`define UFIC_IID_TO 4'hC
`define UFIC_IID_TXE 4'h2

// Character times before a receive time-out
`define UFIC_TO_CHARS 7'h04

`endif

/* logic/ufic_pkg.sv */
// Types shared by the UART FIFO and interrupt control block
package ufic_pkg;

  // One received character with its error flags
  typedef struct packed {
    logic breakInt;
    logic framingErr;
    logic parityErr;
    logic [7:0] data;
  } ufic_rx_char_t;

  // Transmit-empty interrupt progress
  typedef enum logic [1:0] {
    TxeIdle,
    TxeWait,
    TxePend
  } ufic_txe_state_t;

endpackage

/* logic/ufic_uart_fifo_ctrl.sv */
// UART FIFO control, interrupt prioritisation and APB registers
// What this block does
// - FIFO enable change empties both FIFOs
// - Other control bits need enable in write
// - Receive reset empties receive FIFO, self-clears
// - Transmit reset empties transmit FIFO, self-clears
// - Top control bits pick 1/4/8/14 trigger
// - Data available while fill reaches trigger
// - Line status outranks data available
// - Data ready follows receive FIFO non-empty
// - Time-out after four idle character times
// - Character time counted in receive bit ticks
// - Read during time-out clears it and timer
// - Timer restarts on new character or read
// - Transmit empty raised, cleared by write/read
// - Short bursts in FIFO mode delay empty by one character less its final stop bit
// - First transmit interrupt after enable immediate
// - Enables cleared gives polled FIFO operation
// - Enable bits gate data, empty, status
// - Four priority levels: status, time-out, data, empty
// - Identification bit 0 low when pending
// - Bit 3 flags time-out in FIFO mode
// - Bits 5:4 zero, 7:6 show FIFO enable
// - Status read clears line status interrupt
// - Overrun/parity/framing/break raise line status
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "ufic_defines.svh"
module ufic_uart_fifo_ctrl #(
  parameter int Depth = 16,
  parameter int CountW = 5
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver side
  input wire logic rxCharValid,
  input wire ufic_pkg::ufic_rx_char_t rxChar,
  input wire logic rxBitTick,
  input wire logic [3:0] charBits,
  input wire logic stopTwo,
  // Transmitter side
  input wire logic txTake,
  input wire logic txShiftIdle,
  output logic txValid,
  output logic [7:0] txData,
  // Interrupt
  output logic interruptOutput
);

  localparam int PtrW = $clog2(Depth);

  logic [2:0] intEnable_q;
  logic fifoEn_q;
  logic [1:0] trigSel_q;
  ufic_pkg::ufic_rx_char_t rxMem [Depth];
  logic [7:0] txMem [Depth];
  logic [PtrW-1:0] rxWr_q, rxRd_q, txWr_q, txRd_q;
  logic [CountW-1:0] rxCount_q, txCount_q;
  logic [3:0] lineErr_q;
  logic [6:0] toCnt_q;
  logic toPend_q;
  ufic_pkg::ufic_txe_state_t txeState_q;
  logic [3:0] txeCnt_q;
  logic twoSeen_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q, txValid_q;
  logic [7:0] txData_q;

  function automatic logic [CountW-1:0] trigLevel(input logic [1:0] sel);
    case (sel)
      2'h0: trigLevel = CountW'(`UFIC_TRIG_L0);
      2'h1: trigLevel = CountW'(`UFIC_TRIG_L1);
      2'h2: trigLevel = CountW'(`UFIC_TRIG_L2);
      default: trigLevel = CountW'(`UFIC_TRIG_L3);
    endcase
  endfunction

  // Bus decode; effects land on the completing edge only
  logic [5:0] idx;
  logic mapped, apbDone, wrDone, rdDone, capture;
  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx == `UFIC_IDX_RBUF ||
    idx == `UFIC_IDX_IEN || idx == `UFIC_IDX_IID || idx == `UFIC_IDX_LSTAT);
  assign apbDone = psel && penable && pready_q;
  assign wrDone = apbDone && pwrite && mapped;
  assign rdDone = apbDone && !pwrite && mapped;
  assign capture = psel && penable && !pready_q;

  // FIFO events
  logic fctlWr, enChange, rxClr, txClr, rxFull, txFull;
  logic rxPush, rxPop, txPush, txPop, lstatRd, overrun, emptyEvt;
  logic [CountW-1:0] cap;
  assign fctlWr = wrDone && idx == `UFIC_IDX_IID;
  assign enChange = fctlWr && (pwdata[`UFIC_FCTL_EN] != fifoEn_q);
  assign rxClr = enChange || (fctlWr && pwdata[`UFIC_FCTL_EN] &&
    pwdata[`UFIC_FCTL_RXRST]);
  assign txClr = enChange || (fctlWr && pwdata[`UFIC_FCTL_EN] &&
    pwdata[`UFIC_FCTL_TXRST]);
  // Without FIFOs the buffers act as single holding registers
  assign cap = fifoEn_q ? CountW'(Depth) : CountW'(1);
  assign rxFull = rxCount_q >= cap;
  assign txFull = txCount_q >= cap;
  assign rxPush = rxCharValid && !rxFull && !rxClr;
  assign overrun = rxCharValid && rxFull && !rxClr;
  assign rxPop = rdDone && idx == `UFIC_IDX_RBUF && rxCount_q != '0;
  assign txPush = wrDone && idx == `UFIC_IDX_RBUF && !txFull && !txClr;
  assign txPop = txTake && txValid_q && !txClr;
  assign lstatRd = rdDone && idx == `UFIC_IDX_LSTAT;
  assign emptyEvt = txClr || (txPop && !txPush && txCount_q == CountW'(1));

  // Configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intEnable_q <= `UFIC_IEN_RST;
      fifoEn_q <= `UFIC_FIFO_EN_RST;
      trigSel_q <= `UFIC_TRIG_RST;
    end else if (ce) begin
      if (wrDone && idx == `UFIC_IDX_IEN) begin
        intEnable_q <= pwdata[2:0];
      end
      if (fctlWr) begin
        fifoEn_q <= pwdata[`UFIC_FCTL_EN];
        if (pwdata[`UFIC_FCTL_EN]) begin
          trigSel_q <= pwdata[`UFIC_FCTL_TRIG_HI:`UFIC_FCTL_TRIG_LO];
        end
      end
    end
  end

  // Receive FIFO; the shifter outside is never touched by a reset
  always_ff @(posedge clk) begin
    if (ce && rxPush) begin
      rxMem[rxWr_q] <= rxChar;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxWr_q <= '0;
      rxRd_q <= '0;
      rxCount_q <= '0;
    end else if (ce) begin
      if (rxClr) begin
        rxWr_q <= '0;
        rxRd_q <= '0;
        rxCount_q <= '0;
      end else begin
        if (rxPush) begin
          rxWr_q <= rxWr_q + PtrW'(1);
        end
        if (rxPop) begin
          rxRd_q <= rxRd_q + PtrW'(1);
        end
        rxCount_q <= rxCount_q + CountW'(rxPush) - CountW'(rxPop);
      end
    end
  end

  // Transmit FIFO
  always_ff @(posedge clk) begin
    if (ce && txPush) begin
      txMem[txWr_q] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txWr_q <= '0;
      txRd_q <= '0;
      txCount_q <= '0;
    end else if (ce) begin
      if (txClr) begin
        txWr_q <= '0;
        txRd_q <= '0;
        txCount_q <= '0;
      end else begin
        if (txPush) begin
          txWr_q <= txWr_q + PtrW'(1);
        end
        if (txPop) begin
          txRd_q <= txRd_q + PtrW'(1);
        end
        txCount_q <= txCount_q + CountW'(txPush) - CountW'(txPop);
      end
    end
  end

  // Head of the transmit FIFO; valid drops for a cycle after each take
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txValid_q <= 1'b0;
      txData_q <= 8'h00;
    end else if (ce) begin
      txValid_q <= txCount_q != '0 && !txPop && !txClr;
      txData_q <= txMem[txRd_q];
    end
  end

  // Line errors, sticky; a new error wins over a status read
  logic [3:0] newErr;
  assign newErr = {rxCharValid && rxChar.breakInt,
    rxCharValid && rxChar.framingErr, rxCharValid && rxChar.parityErr,
    overrun};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lineErr_q <= 4'h0;
    end else if (ce) begin
      lineErr_q <= (lstatRd ? 4'h0 : lineErr_q) | newErr;
    end
  end

  // Character time-out, measured in receive bit ticks
  logic [6:0] toLimit;
  assign toLimit = `UFIC_TO_CHARS * (7'(charBits) + 7'(stopTwo));
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      toCnt_q <= 7'h00;
      toPend_q <= 1'b0;
    end else if (ce) begin
      if (rxClr || rxCount_q == '0 || !fifoEn_q) begin
        toCnt_q <= 7'h00;
        toPend_q <= 1'b0;
      end else if (toPend_q) begin
        if (rxPop) begin
          toCnt_q <= 7'h00;
          toPend_q <= 1'b0;
        end
      end else if (rxPush || rxPop) begin
        toCnt_q <= 7'h00;
      end else if (rxBitTick) begin
        toCnt_q <= toCnt_q + 7'h01;
        if (toCnt_q + 7'h01 >= toLimit) begin
          toPend_q <= 1'b1;
        end
      end
    end
  end

  // Pending sources and identification
  logic lsIrq, rdaIrq, toIrq, txeIrq;
  logic [3:0] iidCode;
  logic [7:0] iidByte, lstatByte, rdMux;
  assign lsIrq = intEnable_q[`UFIC_IEN_LS] && lineErr_q != 4'h0;
  // Polled mode falls out of the enable gating
  assign rdaIrq = intEnable_q[`UFIC_IEN_RDA] && (fifoEn_q ?
    rxCount_q >= trigLevel(trigSel_q) : rxCount_q != '0);
  assign toIrq = intEnable_q[`UFIC_IEN_RDA] && fifoEn_q && toPend_q;
  assign txeIrq = intEnable_q[`UFIC_IEN_TXE] &&
    txeState_q == ufic_pkg::TxePend;

  always_comb begin
    if (lsIrq) begin
      iidCode = `UFIC_IID_LS;
    end else if (toIrq) begin
      iidCode = `UFIC_IID_TO;
    end else if (rdaIrq) begin
      iidCode = `UFIC_IID_RDA;
    end else if (txeIrq) begin
      iidCode = `UFIC_IID_TXE;
    end else begin
      iidCode = `UFIC_IID_NONE;
    end
  end

  assign iidByte = {fifoEn_q, fifoEn_q, 2'h0, iidCode};
  assign lstatByte = {fifoEn_q && lineErr_q[3:1] != 3'h0,
    txCount_q == '0 && txShiftIdle, txCount_q == '0, lineErr_q,
    rxCount_q != '0};

  // Transmit-empty interrupt sequencing
  logic txeRdClr;
  assign txeRdClr = rdDone && idx == `UFIC_IDX_IID &&
    iidCode == `UFIC_IID_TXE;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txeState_q <= ufic_pkg::TxePend;
      txeCnt_q <= 4'h0;
    end else if (ce) begin
      if (enChange) begin
        txeState_q <= ufic_pkg::TxePend;
        txeCnt_q <= 4'h0;
      end else begin
        case (txeState_q)
          ufic_pkg::TxeIdle: begin
            txeCnt_q <= 4'h0;
            if (emptyEvt) begin
              txeState_q <= (twoSeen_q || !fifoEn_q) ?
                ufic_pkg::TxePend : ufic_pkg::TxeWait;
            end
          end
          ufic_pkg::TxeWait: begin
            if (txPush) begin
              txeState_q <= ufic_pkg::TxeIdle;
            end else if (rxBitTick) begin
              txeCnt_q <= txeCnt_q + 4'h1;
              // One character less its final stop bit
              if (txeCnt_q + 4'h1 >= charBits - 4'h1) begin
                txeState_q <= ufic_pkg::TxePend;
              end
            end
          end
          ufic_pkg::TxePend: begin
            if (txPush || txeRdClr) begin
              txeState_q <= ufic_pkg::TxeIdle;
            end
          end
          default: txeState_q <= ufic_pkg::TxeIdle;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      twoSeen_q <= 1'b0;
    end else if (ce) begin
      twoSeen_q <= txCount_q >= CountW'(2) || (twoSeen_q && !emptyEvt);
    end
  end

  // Read data selection
  always_comb begin
    case (idx)
      `UFIC_IDX_RBUF: rdMux = rxCount_q != '0 ? rxMem[rxRd_q].data : 8'h00;
      `UFIC_IDX_IEN: rdMux = {5'h00, intEnable_q};
      `UFIC_IDX_IID: rdMux = iidByte;
      `UFIC_IDX_LSTAT: rdMux = lstatByte;
      default: rdMux = 8'h00;
    endcase
  end

  // APB answer: one wait state, unmapped addresses get pslverr
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= capture;
      pslverr_q <= capture && !mapped;
      prdata_q <= (capture && !pwrite && mapped) ? {24'h000000, rdMux} :
        32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= !iidCode[0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txValid = txValid_q;
  assign txData = txData_q;
  assign interruptOutput = irq_q;

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_fctl_write;
    ce && fctlWr;
  endsequence

  sequence s_short_empty;
    ce && txeState_q == ufic_pkg::TxeIdle && emptyEvt && !twoSeen_q &&
      fifoEn_q && !enChange;
  endsequence

  property p_en_change_clears;
    ce && enChange |=> rxCount_q == '0 && txCount_q == '0;
  endproperty
  a_en_change_clears: assert property (p_en_change_clears)
    else $error("FIFO enable change did not empty FIFOs");

  property p_ctl_needs_en;
    s_fctl_write and (ce && !pwdata[`UFIC_FCTL_EN]) |=>
      trigSel_q == $past(trigSel_q);
  endproperty
  a_ctl_needs_en: assert property (p_ctl_needs_en)
    else $error("Trigger changed without FIFO enable");

  property p_rx_reset;
    s_fctl_write and (ce && pwdata[0] && pwdata[1]) |=> rxCount_q == '0;
  endproperty
  a_rx_reset: assert property (p_rx_reset)
    else $error("Receive reset left data");

  property p_tx_reset;
    s_fctl_write and (ce && pwdata[0] && pwdata[2]) |=> txCount_q == '0;
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("Transmit reset left data");

  property p_ls_first;
    ce && capture && !pwrite && idx == `UFIC_IDX_IID && lsIrq |=>
      prdata[3:0] == `UFIC_IID_LS && interruptOutput;
  endproperty
  a_ls_first: assert property (p_ls_first)
    else $error("Line status not at top priority");

  property p_dr_set;
    ce && rxPush |=> lstatByte[0];
  endproperty
  a_dr_set: assert property (p_dr_set)
    else $error("Data ready missing after push");

  property p_to_clear;
    ce && toPend_q && rxPop && !rxClr |=> !toPend_q && toCnt_q == 7'h00;
  endproperty
  a_to_clear: assert property (p_to_clear)
    else $error("Time-out not cleared by read");

  property p_short_delay;
    s_short_empty |=> txeState_q == ufic_pkg::TxeWait;
  endproperty
  a_short_delay: assert property (p_short_delay)
    else $error("Short burst empty not delayed");

  property p_first_immediate;
    ce && enChange |=> txeState_q == ufic_pkg::TxePend;
  endproperty
  a_first_immediate: assert property (p_first_immediate)
    else $error("First transmit interrupt not immediate");

  property p_iid_upper;
    ce && capture && !pwrite && idx == `UFIC_IDX_IID |=>
      prdata[7:6] == {fifoEn_q, fifoEn_q} && prdata[5:4] == 2'h0 &&
      (fifoEn_q || !prdata[3]);
  endproperty
  a_iid_upper: assert property (p_iid_upper)
    else $error("Identification upper bits wrong");

  property p_irq_pin;
    ce && lsIrq |=> interruptOutput;
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("Interrupt output missing");

endmodule

/* tb/ufic_peer_model.sv */
// Remote serial peer: receive bit ticks, received characters, shifter
`timescale 1ns/1ns
module ufic_peer_model #(
  parameter int TickDiv = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Receive side
  output logic rxCharValid,
  output ufic_pkg::ufic_rx_char_t rxChar,
  output logic rxBitTick,
  input wire logic [3:0] charBits,
  // Transmit side
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic stall,
  output logic txTake,
  output logic txShiftIdle
);
  int tickCnt;
  int busy;
  logic [7:0] txLog[$];

  initial begin
    rxCharValid = 1'b0;
    rxChar = '0;
  end

  // Baud ticks run free, so character time scales with them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt <= 0;
      rxBitTick <= 1'b0;
    end else begin
      tickCnt <= (tickCnt == TickDiv - 1) ? 0 : tickCnt + 1;
      rxBitTick <= (tickCnt == TickDiv - 1);
    end
  end

  // A character lands only after a whole frame of ticks
  task automatic send(input logic [2:0] err, input logic [7:0] d);
    repeat (charBits) begin
      @(posedge clk);
      while (rxBitTick !== 1'b1) @(posedge clk);
    end
    rxCharValid <= 1'b1;
    rxChar <= {err, d};
    @(posedge clk);
    rxCharValid <= 1'b0;
    rxChar <= ~{err, d};
  endtask

  // Shifter takes a byte only when idle; stall holds it off
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txTake <= 1'b0;
      busy <= 0;
    end else begin
      txTake <= 1'b0;
      if (busy != 0) begin
        busy <= busy - 1;
      end else if (txValid && !txTake && !stall) begin
        txTake <= 1'b1;
        busy <= charBits * TickDiv;
        txLog.push_back(txData);
      end
    end
  end

  assign txShiftIdle = (busy == 0) && !txTake;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the FIFO and interrupt control block
`timescale 1ns/1ns
`include "ufic_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam logic [7:0] ABuf = {`UFIC_IDX_RBUF, 2'b00};
  localparam logic [7:0] AIen = {`UFIC_IDX_IEN, 2'b00};
  localparam logic [7:0] AIid = {`UFIC_IDX_IID, 2'b00};
  localparam logic [7:0] ALst = {`UFIC_IDX_LSTAT, 2'b00};
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, stall;
  logic ce, stopTwo;
  logic [7:0] paddr, txData;
  logic [31:0] pwdata, prdata, r;
  logic rxCharValid, rxBitTick, txTake, txShiftIdle, txValid, irqOut, e;
  ufic_pkg::ufic_rx_char_t rxChar;
  logic [3:0] charBits;
  int n_mismatch = 0;
  int tests_run = 0;
  int trig[4] = '{1, 4, 8, 14};

  ufic_uart_fifo_ctrl ufic_uart_fifo_ctrl_i (.clk(clk), .nrst(nrst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxCharValid(rxCharValid), .rxChar(rxChar),
    .rxBitTick(rxBitTick), .charBits(charBits), .stopTwo(stopTwo),
    .txTake(txTake), .txShiftIdle(txShiftIdle), .txValid(txValid),
    .txData(txData), .interruptOutput(irqOut));

  ufic_peer_model ufic_peer_model_i (.clk(clk), .nrst(nrst),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .rxBitTick(rxBitTick),
    .charBits(charBits), .txValid(txValid), .txData(txData),
    .stall(stall), .txTake(txTake), .txShiftIdle(txShiftIdle));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Setup, then hold the access until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    `CHK(n < 20, 1'b1)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 8'h00, x, y);
    `CHK(x, {24'h000000, exp})
    // Pin mirrors the pending flag of the identification value
    if (a == AIid) `CHK(irqOut, ~exp[0])
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      while (rxBitTick !== 1'b1) @(posedge clk);
    end
  endtask

  task automatic tx_wait(input int n);
    int k;
    k = 0;
    while (ufic_peer_model_i.txLog.size() < n && k < 2000) begin
      @(posedge clk);
      k++;
    end
    `CHK(ufic_peer_model_i.txLog.size(), n)
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles; twenty thousand is a hang
  initial begin
    #400000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, stall, stopTwo} = 5'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    charBits = 4'hA;
    nrst = 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(AIid, 8'h01);
    rd(AIen, 8'h00);
    apb(1'b0, 8'h0C, 8'h00, r, e);
    `CHK(e, 1'b1)
    wr(AIid, 8'hC6);
    rd(AIid, 8'h01);
    wr(AIen, 8'h01);
    ufic_peer_model_i.send(3'h0, 8'h5A);
    rd(AIid, 8'h04);
    rd(ABuf, 8'h5A);
    rd(AIid, 8'h01);
    wr(AIen, 8'h02);
    rd(AIid, 8'h02);
    wr(AIid, 8'h01);
    rd(AIid, 8'hC2);
    rd(AIid, 8'hC1);
    $display("test reset and enable done");
    wr(AIen, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(AIid, {i[1:0], 6'h03});
      for (int j = 0; j < trig[i] - 1; j++) begin
        ufic_peer_model_i.send(3'h0, 8'h10 + j[7:0]);
      end
      rd(AIid, 8'hC1);
      ufic_peer_model_i.send(3'h0, 8'h2F);
      rd(AIid, 8'hC4);
      rd(ABuf, (i == 0) ? 8'h2F : 8'h10);
      rd(AIid, 8'hC1);
    end
    $display("test trigger levels done");
    wr(AIid, 8'h07);
    wr(AIen, 8'h05);
    ufic_peer_model_i.send(3'h1, 8'h77);
    rd(AIid, 8'hC6);
    rd(ALst, 8'hE5);
    rd(AIid, 8'hC4);
    rd(ABuf, 8'h77);
    wr(AIid, 8'hC1);
    wr(AIen, 8'h01);
    ufic_peer_model_i.send(3'h0, 8'h33);
    ticks(30);
    rd(AIid, 8'hC1);
    ticks(20);
    rd(AIid, 8'hCC);
    rd(ABuf, 8'h33);
    rd(AIid, 8'hC1);
    // Second stop bit stretches the limit from 40 to 44 ticks
    stopTwo <= 1'b1;
    ufic_peer_model_i.send(3'h0, 8'h3C);
    ticks(42);
    rd(AIid, 8'hC1);
    ticks(5);
    rd(AIid, 8'hCC);
    rd(ABuf, 8'h3C);
    stopTwo <= 1'b0;
    $display("test line status and time-out done");
    wr(AIen, 8'h00);
    ufic_peer_model_i.send(3'h0, 8'h44);
    ticks(50);
    rd(AIid, 8'hC1);
    rd(ALst, 8'h61);
    rd(ABuf, 8'h44);
    rd(ALst, 8'h60);
    // A frozen block must miss a character offered while ce is low
    ce <= 1'b0;
    ufic_peer_model_i.send(3'h0, 8'h66);
    ce <= 1'b1;
    rd(ALst, 8'h60);
    $display("test polled mode done");
    wr(AIen, 8'h02);
    stall <= 1'b1;
    wr(ABuf, 8'hA1);
    wr(ABuf, 8'hA2);
    wr(ABuf, 8'hA3);
    rd(AIid, 8'hC1);
    stall <= 1'b0;
    tx_wait(3);
    `CHK({ufic_peer_model_i.txLog[0], ufic_peer_model_i.txLog[2]}, 16'hA1A3)
    rd(AIid, 8'hC2);
    stall <= 1'b1;
    wr(ABuf, 8'hB0);
    wr(AIid, 8'h05);
    stall <= 1'b0;
    // Shifter still busy with the last byte, so only FIFO empty shows
    rd(ALst, 8'h20);
    apb(1'b0, AIid, 8'h00, r, e);
    `CHK(r, 32'h0000_00C1)
    wr(ABuf, 8'hB1);
    tx_wait(4);
    rd(AIid, 8'hC1);
    ticks(12);
    rd(AIid, 8'hC2);
    $display("test transmit done");
    stall <= 1'b1;
    wr(ABuf, 8'hC9);
    ufic_peer_model_i.send(3'h0, 8'h55);
    wr(AIid, 8'h00);
    stall <= 1'b0;
    rd(ALst, 8'h60);
    rd(AIid, 8'h02);
    tx_wait(4);
    $display("test enable change done");
    print_verdict();
  end
endmodule
